/* File: common/slc_pkg.sv */
// Purpose: constants shared by the servo loop controller files
// Assumes: 20 MHz core clock, one control update per millisecond
// Notes: offsets are byte addresses on the register bus
package slc_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50; // core clock period
  localparam int CTRL_PERIOD_NS = 1000000; // 1000 updates per second
  localparam int TICK_CYCLES = CTRL_PERIOD_NS / CLK_PERIOD_NS; // core cycles per update

  // ------------------------------------------------------------
  // widths and scaling
  // ------------------------------------------------------------
  localparam int FB_W = 12; // feedback conversion width
  localparam int CMD_W = 12; // signed command width
  localparam int GAIN_W = 16; // signed gain width
  localparam int GAIN_FRAC = 8; // gains are 8.8 fixed point
  localparam int TERM_W = 24; // width of each scaled term
  localparam int SUM_W = 27; // room for five terms
  localparam int DRIVE_W = 16; // valve drive width
  localparam int ADDR_W = 6; // byte address width
  localparam logic [FB_W:0] FB_MID = 13'h0800; // mid scale of the converter

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00; // mode and polarities
  localparam logic [ADDR_W-1:0] OFS_PROP_GAIN = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_INTEGRAL_GAIN = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_DERIVATIVE_GAIN = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_INTEGRATOR_WINDOW = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_DEADBAND_A = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_DEADBAND_B = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_FEEDFORWARD_GAIN = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_DRIVE = 6'h20; // read only
  localparam logic [ADDR_W-1:0] OFS_ERROR = 6'h24; // read only
  localparam logic [ADDR_W-1:0] OFS_INTEGRATOR = 6'h28; // read only
  localparam logic [ADDR_W-1:0] OFS_UPDATES = 6'h2C; // read only

  // ------------------------------------------------------------
  // control fields and reset values
  // ------------------------------------------------------------
  localparam int MODE_LSB = 0; // loop_mode_select, two bits
  localparam int CMD_POL_BIT = 2; // command_polarity
  localparam int FB_POL_BIT = 3; // feedback_polarity
  localparam logic [1:0] MODE_OPEN = 2'h0; // loop terms off
  localparam logic [1:0] MODE_CLOSED_EXT = 2'h2; // external feedback loop
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [GAIN_W-1:0] GAIN_RST = 16'h0000;
  localparam logic [FB_W-1:0] WINDOW_RST = 12'h000;

  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } slc_bus_state_t;
endpackage

/* File: hw/slc_tick_gen.sv */
// Purpose: divides the core clock into the control update enable
// Assumes: one clock domain, synchronous active high reset
// Notes: first pulse arrives CYCLES-1 cycles after the last reset edge
`timescale 1ns/1ns
module slc_tick_gen #(
  parameter int CYCLES = 20000
) (
  input wire logic i_clk,
  input wire logic i_rst,
  output logic o_tick
);
  localparam int CW = (CYCLES > 2) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  generate
    if (CYCLES < 2) begin : g_bad
      $error("tick divider needs at least two cycles");
    end
  endgenerate

  logic [CW-1:0] cnt_reg; // cycles since last pulse

  // free running divider, wraps at the last count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= '0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // pulse for exactly one cycle per period
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= (cnt_reg == LAST - 1'b1);
    end
  end
endmodule

/* File: hw/slc_gain_term.sv */
// Purpose: fixed point gain times signed value, saturated
// Assumes: gain carries FRAC fraction bits
// Notes: purely combinational; caller registers the result
`timescale 1ns/1ns
module slc_gain_term #(
  parameter int IN_W = 14,
  parameter int GAIN_W = 16,
  parameter int FRAC = 8,
  parameter int OUT_W = 24
) (
  input wire logic signed [IN_W-1:0] i_value,
  input wire logic signed [GAIN_W-1:0] i_gain,
  output logic signed [OUT_W-1:0] o_term
);
  localparam int PW = IN_W + GAIN_W;
  localparam logic signed [PW-1:0] MAXV = {{(PW-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}};
  localparam logic signed [PW-1:0] MINV = {{(PW-OUT_W+1){1'b1}}, {(OUT_W-1){1'b0}}};

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  generate
    if (OUT_W > PW || FRAC >= PW) begin : g_bad
      $error("gain term widths cannot be served");
    end
  endgenerate

  logic signed [PW-1:0] prod; // full product
  logic signed [PW-1:0] scaled; // fraction bits dropped

  assign prod = i_value * i_gain;
  assign scaled = prod >>> FRAC;

  // clip instead of wrapping: a wrapped term would reverse the valve
  always_comb begin
    if (scaled > MAXV) begin
      o_term = MAXV[OUT_W-1:0];
    end else if (scaled < MINV) begin
      o_term = MINV[OUT_W-1:0];
    end else begin
      o_term = scaled[OUT_W-1:0];
    end
  end
endmodule

/* File: hw/slc_servo_loop.sv */
// Purpose: servo loop controller with Avalon-MM register slave
// Assumes: command and feedback are synchronous to the core clock
// Notes: all loop state changes only on the millisecond update
//
// Behaviour
// RULE_01 - drive output recomputed once per millisecond
// RULE_02 - output sums weighted P, I, D terms
// RULE_03 - P term is gain times command minus feedback
// RULE_04 - integrator accumulates gain times error each update
// RULE_05 - zero window disables integral action entirely
// RULE_06 - D term follows per-update feedback change
// RULE_07 - nonzero command adds per-side deadband offset
// RULE_08 - feedforward adds bypass gain times command
// RULE_09 - mode 0 open loop, mode 2 closed
// RULE_10 - command and feedback each optionally negated
// RULE_11 - feedback is a 12-bit conversion result
// RULE_12 - integrate inside window only; saturate output
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module slc_servo_loop
  import slc_pkg::*;
#(
  parameter int TICK = TICK_CYCLES
) (
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  input wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic signed [CMD_W-1:0] I_COMMAND,
  input wire logic [FB_W-1:0] I_FEEDBACK,
  output logic signed [DRIVE_W-1:0] O_VALVE_DRIVE,
  output logic O_UPDATE_STROBE
);
  localparam logic signed [SUM_W-1:0] DRV_MAX = {{(SUM_W-DRIVE_W+1){1'b0}}, {(DRIVE_W-1){1'b1}}};
  localparam logic signed [SUM_W-1:0] DRV_MIN = {{(SUM_W-DRIVE_W+1){1'b1}}, {(DRIVE_W-1){1'b0}}};
  localparam logic signed [TERM_W:0] ACC_MAX = {2'b00, {(TERM_W-1){1'b1}}};
  localparam logic signed [TERM_W:0] ACC_MIN = {2'b11, {(TERM_W-1){1'b0}}};

  // ------------------------------------------------------------
  // update tick
  // ------------------------------------------------------------
  logic tick; // one cycle per control period

  slc_tick_gen #(
    .CYCLES(TICK)
  ) u_tick (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .o_tick(tick)
  );

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [3:0] ctrl_reg; // mode and polarity bits
  logic [GAIN_W-1:0] prop_gain_reg;
  logic [GAIN_W-1:0] integral_gain_reg;
  logic [GAIN_W-1:0] derivative_gain_reg; // signed
  logic [FB_W-1:0] integrator_window_reg; // zero turns integral off
  logic [GAIN_W-1:0] deadband_a_reg; // magnitude, positive side
  logic [GAIN_W-1:0] deadband_b_reg; // magnitude, negative side
  logic [GAIN_W-1:0] feedforward_gain_reg;
  slc_bus_state_t bus_state; // handshake phase
  logic bus_req; // read or write pending
  logic bus_take; // edge at which request completes

  assign bus_req = I_AVS_READ | I_AVS_WRITE;
  assign bus_take = bus_req && (bus_state == BUS_ACK);
  // waitrequest drops for one cycle after the request was seen
  assign O_AVS_WAITREQUEST = bus_req && (bus_state != BUS_ACK);

  // one wait cycle gives time to register read data
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (bus_req) begin
            bus_state <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_state <= BUS_IDLE;
        end
        default: begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // writes land on the completing edge; other offsets are ignored
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      ctrl_reg <= CTRL_RST;
      prop_gain_reg <= GAIN_RST;
      integral_gain_reg <= GAIN_RST;
      derivative_gain_reg <= GAIN_RST;
      integrator_window_reg <= WINDOW_RST;
      deadband_a_reg <= GAIN_RST;
      deadband_b_reg <= GAIN_RST;
      feedforward_gain_reg <= GAIN_RST;
    end else if (bus_take && I_AVS_WRITE) begin
      case (I_AVS_ADDRESS)
        OFS_CTRL: ctrl_reg <= I_AVS_WRITEDATA[3:0];
        OFS_PROP_GAIN: prop_gain_reg <= I_AVS_WRITEDATA[GAIN_W-1:0];
        OFS_INTEGRAL_GAIN: integral_gain_reg <= I_AVS_WRITEDATA[GAIN_W-1:0];
        OFS_DERIVATIVE_GAIN: derivative_gain_reg <= I_AVS_WRITEDATA[GAIN_W-1:0];
        OFS_INTEGRATOR_WINDOW: integrator_window_reg <= I_AVS_WRITEDATA[FB_W-1:0];
        OFS_DEADBAND_A: deadband_a_reg <= I_AVS_WRITEDATA[GAIN_W-1:0];
        OFS_DEADBAND_B: deadband_b_reg <= I_AVS_WRITEDATA[GAIN_W-1:0];
        OFS_FEEDFORWARD_GAIN: feedforward_gain_reg <= I_AVS_WRITEDATA[GAIN_W-1:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // input conditioning
  // ------------------------------------------------------------
  logic [1:0] mode; // loop_mode_select
  logic signed [CMD_W:0] cmd_s; // command after polarity
  logic signed [FB_W:0] fb_ext; // converter result, centred
  logic signed [FB_W:0] fb_s; // feedback after polarity
  logic signed [FB_W+1:0] err; // command minus feedback
  logic [FB_W+1:0] abs_err; // error magnitude
  logic signed [FB_W+1:0] dfb; // feedback change per update
  logic signed [FB_W:0] fb_prev_reg; // feedback at last update
  logic closed; // closed loop selected
  logic win_on; // integral action allowed
  logic integ_gate; // integrator moves this update

  assign mode = ctrl_reg[MODE_LSB+1:MODE_LSB];
  assign closed = (mode == MODE_CLOSED_EXT); // RULE_09
  assign cmd_s = ctrl_reg[CMD_POL_BIT] ? -{I_COMMAND[CMD_W-1], I_COMMAND}
                                       : {I_COMMAND[CMD_W-1], I_COMMAND}; // RULE_10
  // offset-binary 12-bit sample, mid scale reads as zero
  assign fb_ext = $signed({1'b0, I_FEEDBACK} - FB_MID); // RULE_11
  assign fb_s = ctrl_reg[FB_POL_BIT] ? -fb_ext : fb_ext; // RULE_10
  assign err = {cmd_s[CMD_W], cmd_s} - {fb_s[FB_W], fb_s}; // RULE_03
  assign abs_err = err[FB_W+1] ? $unsigned(-err) : $unsigned(err);
  assign dfb = {fb_s[FB_W], fb_s} - {fb_prev_reg[FB_W], fb_prev_reg}; // RULE_06
  assign win_on = (integrator_window_reg != WINDOW_RST); // RULE_05
  // outside the window the integrator holds, which stops the limit cycle
  assign integ_gate = closed && win_on && (abs_err < {2'b00, integrator_window_reg}); // RULE_12

  // ------------------------------------------------------------
  // weighted terms
  // ------------------------------------------------------------
  logic signed [TERM_W-1:0] p_term; // proportional
  logic signed [TERM_W-1:0] i_inc; // integrator step
  logic signed [TERM_W-1:0] d_term; // derivative
  logic signed [TERM_W-1:0] ff_term; // feedforward bypass
  logic signed [TERM_W-1:0] db_term; // deadband jump
  logic signed [TERM_W-1:0] integ_reg; // integrator state
  logic signed [TERM_W:0] integ_wide; // unclipped next state
  logic signed [TERM_W-1:0] integ_upd; // state after this update
  logic signed [TERM_W-1:0] i_term; // integral contribution

  slc_gain_term #(.IN_W(FB_W+2), .GAIN_W(GAIN_W), .FRAC(GAIN_FRAC), .OUT_W(TERM_W)) u_p (
    .i_value(err),
    .i_gain(prop_gain_reg),
    .o_term(p_term)
  ); // RULE_03

  slc_gain_term #(.IN_W(FB_W+2), .GAIN_W(GAIN_W), .FRAC(GAIN_FRAC), .OUT_W(TERM_W)) u_i (
    .i_value(err),
    .i_gain(integral_gain_reg),
    .o_term(i_inc)
  ); // RULE_04

  slc_gain_term #(.IN_W(FB_W+2), .GAIN_W(GAIN_W), .FRAC(GAIN_FRAC), .OUT_W(TERM_W)) u_d (
    .i_value(dfb),
    .i_gain(derivative_gain_reg),
    .o_term(d_term)
  ); // RULE_06

  slc_gain_term #(.IN_W(CMD_W+1), .GAIN_W(GAIN_W), .FRAC(GAIN_FRAC), .OUT_W(TERM_W)) u_ff (
    .i_value(cmd_s),
    .i_gain(feedforward_gain_reg),
    .o_term(ff_term)
  ); // RULE_08

  // integrator clips so a long error cannot wrap its sign
  assign integ_wide = {integ_reg[TERM_W-1], integ_reg} + {i_inc[TERM_W-1], i_inc};
  always_comb begin
    if (!integ_gate) begin
      integ_upd = integ_reg; // hold outside the window
    end else if (integ_wide > ACC_MAX) begin
      integ_upd = ACC_MAX[TERM_W-1:0];
    end else if (integ_wide < ACC_MIN) begin
      integ_upd = ACC_MIN[TERM_W-1:0];
    end else begin
      integ_upd = integ_wide[TERM_W-1:0]; // RULE_04
    end
  end
  assign i_term = (closed && win_on) ? integ_upd : '0; // RULE_05

  // side a for positive command, side b for negative, none at zero
  always_comb begin
    if (cmd_s > 0) begin
      db_term = TERM_W'(deadband_a_reg); // RULE_07
    end else if (cmd_s < 0) begin
      db_term = -TERM_W'(deadband_b_reg); // RULE_07
    end else begin
      db_term = '0;
    end
  end

  // ------------------------------------------------------------
  // summing and saturation
  // ------------------------------------------------------------
  logic signed [SUM_W-1:0] loop_sum; // feedback based terms
  logic signed [SUM_W-1:0] total_sum; // everything added
  logic signed [DRIVE_W-1:0] drive_next; // clipped drive

  // open loop keeps feedforward and deadband so the valve can be jogged
  assign loop_sum = closed ? SUM_W'(p_term) + SUM_W'(i_term) + SUM_W'(d_term) : '0; // RULE_02
  assign total_sum = loop_sum + SUM_W'(ff_term) + SUM_W'(db_term); // RULE_08
  always_comb begin
    if (total_sum > DRV_MAX) begin
      drive_next = DRV_MAX[DRIVE_W-1:0]; // RULE_12
    end else if (total_sum < DRV_MIN) begin
      drive_next = DRV_MIN[DRIVE_W-1:0]; // RULE_12
    end else begin
      drive_next = total_sum[DRIVE_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // loop state, moved only by the tick
  // ------------------------------------------------------------
  logic signed [FB_W+1:0] err_reg; // error of last update
  logic [31:0] updates_reg; // count of updates

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      O_VALVE_DRIVE <= '0;
      fb_prev_reg <= '0;
      err_reg <= '0;
      integ_reg <= '0;
      updates_reg <= '0;
    end else if (tick) begin
      O_VALVE_DRIVE <= drive_next; // RULE_01
      fb_prev_reg <= fb_s; // RULE_06
      err_reg <= err;
      integ_reg <= (closed && win_on) ? integ_upd : '0; // RULE_05
      updates_reg <= updates_reg + 1'b1;
    end
  end

  // strobe marks the cycle the new drive appears
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      O_UPDATE_STROBE <= 1'b0;
    end else begin
      O_UPDATE_STROBE <= tick;
    end
  end

  // read data registered while waitrequest is high
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      O_AVS_READDATA <= '0;
    end else if (I_AVS_READ && bus_state == BUS_IDLE) begin
      case (I_AVS_ADDRESS)
        OFS_CTRL: O_AVS_READDATA <= 32'(ctrl_reg);
        OFS_PROP_GAIN: O_AVS_READDATA <= 32'(prop_gain_reg);
        OFS_INTEGRAL_GAIN: O_AVS_READDATA <= 32'(integral_gain_reg);
        OFS_DERIVATIVE_GAIN: O_AVS_READDATA <= 32'(derivative_gain_reg);
        OFS_INTEGRATOR_WINDOW: O_AVS_READDATA <= 32'(integrator_window_reg);
        OFS_DEADBAND_A: O_AVS_READDATA <= 32'(deadband_a_reg);
        OFS_DEADBAND_B: O_AVS_READDATA <= 32'(deadband_b_reg);
        OFS_FEEDFORWARD_GAIN: O_AVS_READDATA <= 32'(feedforward_gain_reg);
        OFS_DRIVE: O_AVS_READDATA <= 32'($unsigned(O_VALVE_DRIVE));
        OFS_ERROR: O_AVS_READDATA <= 32'($unsigned(err_reg));
        OFS_INTEGRATOR: O_AVS_READDATA <= 32'($unsigned(integ_reg));
        OFS_UPDATES: O_AVS_READDATA <= updates_reg;
        default: O_AVS_READDATA <= '0; // unmapped reads as zero
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [31:0] gap_reg; // cycles since last tick
  logic seen_tick_reg; // first tick seen since reset

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      gap_reg <= '0;
      seen_tick_reg <= 1'b0;
    end else begin
      gap_reg <= tick ? 32'h0000_0000 : gap_reg + 1'b1;
      seen_tick_reg <= seen_tick_reg | tick;
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);

  tick_period_a: assert property (tick && seen_tick_reg |-> gap_reg == 32'(TICK - 1)) // RULE_01
    else $error("update tick period wrong");
  drive_hold_a: assert property (!$past(tick) |-> $stable(O_VALVE_DRIVE)) // RULE_01
    else $error("drive changed between updates");
  drive_sum_a: assert property (tick |=> O_VALVE_DRIVE == $past(drive_next) && O_UPDATE_STROBE) // RULE_02
    else $error("drive not taken from the sum");
  prop_sign_a: assert property (closed && prop_gain_reg[GAIN_W-1] == 1'b0 && err > 0 |-> p_term >= 0) // RULE_03
    else $error("proportional term has wrong sign");
  integ_step_a: assert property (tick && integ_gate && integ_wide <= ACC_MAX && integ_wide >= ACC_MIN
    |=> integ_reg == $past(integ_reg) + $past(i_inc)) // RULE_04
    else $error("integrator did not accumulate");
  window_off_a: assert property ((!win_on |-> i_term == 0) and (!win_on && tick |=> integ_reg == 0)) // RULE_05
    else $error("integral active with zero window");
  deriv_prev_a: assert property (tick |=> fb_prev_reg == $past(fb_s)) // RULE_06
    else $error("previous feedback not kept");
  deadband_sel_a: assert property ((cmd_s == 0 |-> db_term == 0) // RULE_07
    and (cmd_s > 0 |-> db_term == TERM_W'(deadband_a_reg)) and (cmd_s < 0 |-> db_term == -TERM_W'(deadband_b_reg)))
    else $error("deadband offset wrong");
  open_loop_a: assert property (!closed |-> total_sum == SUM_W'(ff_term) + SUM_W'(db_term)) // RULE_09
    else $error("loop terms active in open loop");
  cmd_pol_a: assert property (ctrl_reg[CMD_POL_BIT] |-> (CMD_W+1)'(cmd_s + I_COMMAND) == '0) // RULE_10
    else $error("command polarity not applied");
  integ_hold_a: assert property (tick && win_on && !integ_gate && closed |=> $stable(integ_reg)) // RULE_12
    else $error("integrator moved outside window");
  drive_sat_a: assert property (total_sum > DRV_MAX |-> drive_next == DRV_MAX[DRIVE_W-1:0]) // RULE_12
    else $error("drive not saturated");
  bus_wait_a: assert property (bus_req && bus_state == BUS_IDLE |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST)
    else $error("bus answer not after one wait cycle");

  closed_acc_c: cover property (tick && integ_gate && i_inc != 0);
  drive_clip_c: cover property (tick && total_sum < DRV_MIN);
  bus_write_c: cover property (bus_take && I_AVS_WRITE && I_AVS_ADDRESS == OFS_CTRL);
endmodule

/* File: verification/slc_plant_model.sv */
// Purpose: valve amplifier and feedback transducer stand-in
// Assumes: the bench sets the transducer level
// Notes: feedback is registered, like a converter output
`timescale 1ns/1ns
module slc_plant_model
  import slc_pkg::*;
(
  input wire logic i_clk,
  input wire logic [FB_W-1:0] i_level,
  input wire logic signed [DRIVE_W-1:0] i_drive,
  output logic [FB_W-1:0] o_feedback,
  output logic signed [DRIVE_W-1:0] o_valve
);
  // ------------------------------------------------------------
  // converter and amplifier latch
  // ------------------------------------------------------------
  // one sample a clock; the loop only reads it on its tick
  always_ff @(posedge i_clk) begin
    o_feedback <= i_level;
    o_valve <= i_drive;
  end
endmodule

/* File: verification/slc_servo_loop_tb.sv */
// Purpose: self-checking bench for the servo loop controller
// Assumes: update period shortened to 20 cycles
// Notes: config writes follow an update, so the next update sees them
`timescale 1ns/1ns
module slc_servo_loop_tb;
  import slc_pkg::*;
  localparam int TK = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic [31:0] rbuf;
  logic wait_q;
  logic signed [CMD_W-1:0] cmd = '0;
  logic [FB_W-1:0] lvl = 12'h800;
  logic [FB_W-1:0] fb;
  logic signed [DRIVE_W-1:0] drv;
  logic stb;
  int error_cnt = 0;
  int check_count = 0;
  always #25 clk = ~clk; // 20 MHz
  slc_servo_loop #(.TICK(TK)) i_dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_AVS_ADDRESS(adr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wait_q), .I_COMMAND(cmd), .I_FEEDBACK(fb), .O_VALVE_DRIVE(drv),
    .O_UPDATE_STROBE(stb));
  slc_plant_model i_plant (.i_clk(clk), .i_level(lvl), .i_drive(drv), .o_feedback(fb), .o_valve());
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge; a hang is left to the watchdog
  task automatic bus(input logic r, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= r;
    wr <= ~r;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (wait_q !== 1'b0);
    rbuf = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic upd();
    do begin
      @(negedge clk);
    end while (stb !== 1'b1);
  endtask
  task automatic cfg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    upd();
    bus(1'b0, a, d);
  endtask
  task automatic setin(input logic signed [CMD_W-1:0] c, input logic [FB_W-1:0] l);
    @(posedge clk);
    cmd <= c;
    lvl <= l;
  endtask
  task automatic dchk(input int e);
    upd();
    chk("drive", 32'(e), {{16{drv[15]}}, drv});
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    bus(1'b1, OFS_CTRL, '0);
    chk("ctrl", 32'h0, rbuf);
    bus(1'b0, 6'h30, 32'hFFFF);
    bus(1'b1, 6'h30, '0);
    chk("unmapped", 32'h0, rbuf);
    bus(1'b0, OFS_DRIVE, 32'h1234);
    bus(1'b1, OFS_DRIVE, '0);
    chk("drive_ro", 32'h0, rbuf);
  endtask
  task automatic t_open();
    cfg(OFS_FEEDFORWARD_GAIN, 32'h100);
    cfg(OFS_DEADBAND_A, 32'h5);
    cfg(OFS_DEADBAND_B, 32'h7);
    setin(100, 12'h800);
    dchk(105);
    setin(-100, 12'h800);
    dchk(-107);
    bus(1'b1, OFS_DRIVE, '0);
    chk("drive_reg", 32'h0000FF95, rbuf);
    setin(0, 12'h800);
    dchk(0);
  endtask
  task automatic t_closed();
    cfg(OFS_FEEDFORWARD_GAIN, 32'h0);
    cfg(OFS_DEADBAND_A, 32'h0);
    cfg(OFS_DEADBAND_B, 32'h0);
    cfg(OFS_PROP_GAIN, 32'h200);
    cfg(OFS_INTEGRAL_GAIN, 32'h100);
    setin(100, 12'h828);
    cfg(OFS_CTRL, 32'h2);
    dchk(120);
    setin(100, 12'hFFF);
    dchk(-3894);
    setin(100, 12'h828);
    cfg(OFS_CTRL, 32'h6);
    dchk(-280);
    cfg(OFS_CTRL, 32'hA);
    dchk(280);
    cfg(OFS_CTRL, 32'h2);
    cfg(OFS_PROP_GAIN, 32'h100);
    cfg(OFS_DERIVATIVE_GAIN, 32'h100);
    dchk(60);
    setin(100, 12'h832);
    dchk(60);
    dchk(50);
  endtask
  task automatic t_integ();
    cfg(OFS_DERIVATIVE_GAIN, 32'h0);
    setin(60, 12'h800);
    cfg(OFS_INTEGRATOR_WINDOW, 32'h64);
    dchk(120);
    dchk(180);
    bus(1'b1, OFS_INTEGRATOR, '0);
    chk("integ_reg", 32'h0000_0078, rbuf);
    bus(1'b1, OFS_ERROR, '0);
    chk("err_reg", 32'h0000_003C, rbuf);
    bus(1'b1, OFS_PROP_GAIN, '0);
    chk("prop_gain", 32'h0000_0100, rbuf);
    cfg(OFS_INTEGRATOR_WINDOW, 32'h3C);
    dchk(240);
    cfg(OFS_INTEGRATOR_WINDOW, 32'h0);
    dchk(60);
  endtask
  task automatic t_sat();
    int n;
    cfg(OFS_CTRL, 32'h0);
    cfg(OFS_FEEDFORWARD_GAIN, 32'h7FFF);
    setin(2047, 12'h800);
    dchk(32767);
    setin(-2048, 12'h800);
    dchk(-32768);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (stb !== 1'b1 && n < 100);
    chk("period", 32'(TK), 32'(n));
  endtask
  // ------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // about 37 updates are needed; 3000 cycles leaves ample margin
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_open();
    t_closed();
    t_integ();
    t_sat();
    give_verdict();
  end
endmodule
